// ===== shared/fdb_defines.svh
// Register offsets, field positions and reset values of the FIFO RAM debug block
`ifndef FDB_DEFINES_SVH
`define FDB_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FDB_OFF_TX_WCTL 10'h060
`define FDB_OFF_TX_WLO  10'h064
`define FDB_OFF_TX_RCTL 10'h068
`define FDB_OFF_TX_RLO  10'h06C
`define FDB_OFF_RX_WCTL 10'h070
`define FDB_OFF_RX_WLO  10'h074
`define FDB_OFF_RX_RCTL 10'h078
`define FDB_OFF_RX_RLO  10'h07C

// ----------------------------------------------------------------
// Field positions in control registers
// ----------------------------------------------------------------
`define FDB_REQ_BIT     31
`define FDB_ACK_BIT     30
`define FDB_HI_MSB      23
`define FDB_HI_LSB      16
`define FDB_FIELD_TOP   16
`define FDB_RX_FLD_TOP  14
`define FDB_RX_UNUSED   4'h0

// ----------------------------------------------------------------
// FIFO RAM word layout
// ----------------------------------------------------------------
`define FDB_WORD_W      40
`define FDB_CTL_MSB     39
`define FDB_CTL_LSB     32
`define FDB_LO_MSB      31
`define FDB_RX_KEEP_MSB 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FDB_RST_WORD    32'h0000_0000
`define FDB_RST_BYTE    8'h00

`endif

// ===== shared/fdb_pkg.sv
// Shared types of the FIFO RAM debug block
package fdb_pkg;

    // Low data word of a FIFO RAM entry
    typedef logic [31:0] fdb_word_t;

    // Control byte of a FIFO RAM entry, bits 39:32
    typedef logic [7:0] fdb_ctl_t;

    // Byte-valid code of a frame's last word
    typedef enum logic [1:0] {
        FDB_BV_ALL4,
        FDB_BV_LOW3,
        FDB_BV_LOW2,
        FDB_BV_LOW1
    } fdb_bval_t;

endpackage

// ===== rtl/fdb_fifo_ram_debug.sv
// APB debug access to the transmit and receive FIFO RAMs and pointers
//
// Function
// - Byte-valid code 0..3 marks last-word valid bytes
// - Tx select low: address picks tx RAM word
// - Tx select high: value loads tx write pointer
// - Tx write address reads live write pointer
// - Low tx data word written with control byte
// - Tx read ack follows request four-phase
// - Writes to ack and read data ignored
// - Tx read: RAM word, or tx read pointer
// - Tx read control byte holds frame flags
// - Read-only low word of tx read result
// - Rx write ack follows request four-phase
// - Rx control byte: unused, SOF, EOF, valid
// - Rx write address reads live pointer, loads
// - Low rx data word written into RAM
// - Rx read ack follows request four-phase
// - Rx read: RAM word, or rx read pointer
// - Read-only low word of rx read result
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fdb_defines.svh"

module fdb_fifo_ram_debug #(
    parameter int unsigned tx_ram_addr_width = 8,
    parameter int unsigned rx_ram_addr_width = 8
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [9:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output var  logic [31:0]                  prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    output var  logic [tx_ram_addr_width:0]   tx_wr_ptr,
    output var  logic [tx_ram_addr_width:0]   tx_rd_ptr,
    output var  logic [rx_ram_addr_width:0]   rx_wr_ptr,
    output var  logic [rx_ram_addr_width:0]   rx_rd_ptr
);

    // ----------------------------------------------------------------
    // Widths and elaboration checks
    // ----------------------------------------------------------------
    localparam int unsigned TA = tx_ram_addr_width;
    localparam int unsigned RA = rx_ram_addr_width;

    // RAM word layout: control byte over the low data word
    localparam int unsigned WW = `FDB_WORD_W;
    localparam int unsigned CM = `FDB_CTL_MSB;
    localparam int unsigned CL = `FDB_CTL_LSB;
    localparam int unsigned LM = `FDB_LO_MSB;
    localparam int unsigned RK = `FDB_RX_KEEP_MSB;

    // Address fields must fit below their reserved bits; select bit and
    // pointer both need at least one address bit beneath them
    if (TA < 1 || TA + 2 > `FDB_FIELD_TOP) begin : g_bad_tx_width
        $error("tx_ram_addr_width out of range");
    end
    if (RA < 1 || RA + 2 > `FDB_RX_FLD_TOP) begin : g_bad_rx_width
        $error("rx_ram_addr_width out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                tx_wreq;
        logic                tx_wack;
        fdb_pkg::fdb_ctl_t   tx_whi;
        logic [TA+1:0]       tx_wadx;
        fdb_pkg::fdb_word_t  tx_wlo;
        logic                tx_rreq;
        logic                tx_rack;
        fdb_pkg::fdb_ctl_t   tx_rhi;
        logic [TA+1:0]       tx_radx;
        fdb_pkg::fdb_word_t  tx_rlo;
        logic                rx_wreq;
        logic                rx_wack;
        fdb_pkg::fdb_ctl_t   rx_whi;
        logic [RA+1:0]       rx_wadx;
        fdb_pkg::fdb_word_t  rx_wlo;
        logic                rx_rreq;
        logic                rx_rack;
        fdb_pkg::fdb_ctl_t   rx_rhi;
        logic [RA+1:0]       rx_radx;
        fdb_pkg::fdb_word_t  rx_rlo;
        logic [TA:0]         tx_wptr;
        logic [TA:0]         tx_rptr;
        logic [RA:0]         rx_wptr;
        logic [RA:0]         rx_rptr;
        logic                pready;
        logic                pslverr;
        fdb_pkg::fdb_word_t  prdata;
    } fdb_state_t;

    fdb_state_t s_q;
    fdb_state_t s_d;

    // FIFO RAMs, 40-bit words: control byte over low data word
    // Contents are not reset: a read of an unwritten word is unknown
    logic [WW-1:0] tx_mem [2**TA];
    logic [WW-1:0] rx_mem [2**RA];

    logic          tx_mem_we;
    logic          rx_mem_we;
    logic [WW-1:0] tx_rd_word;
    logic [WW-1:0] rx_rd_word;

    logic        acc_first;
    logic        acc_done;
    logic        addr_hit;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // Bus phase decode
    // ----------------------------------------------------------------
    // First access cycle prepares the answer, second completes it
    // One wait state always; the answer stands for a single cycle
    assign acc_first = psel && penable && !s_q.pready;
    assign acc_done  = psel && penable && s_q.pready;

    // RAM read ports, addressed by the stored read addresses
    assign tx_rd_word = tx_mem[s_q.tx_radx[TA-1:0]];
    assign rx_rd_word = rx_mem[s_q.rx_radx[RA-1:0]];

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Reserved bits read as zero; write-control address fields show
    // the stored select bit over the live write pointer
    always_comb begin
        rd_mux   = `FDB_RST_WORD;
        addr_hit = 1'b1;
        case (paddr)
            `FDB_OFF_TX_WCTL: begin
                rd_mux[`FDB_REQ_BIT]              = s_q.tx_wreq;
                rd_mux[`FDB_ACK_BIT]              = s_q.tx_wack;
                rd_mux[`FDB_HI_MSB:`FDB_HI_LSB]   = s_q.tx_whi;
                rd_mux[TA+1]                      = s_q.tx_wadx[TA+1];
                rd_mux[TA:0]                      = s_q.tx_wptr;
            end
            `FDB_OFF_TX_WLO: begin
                rd_mux = s_q.tx_wlo;
            end
            `FDB_OFF_TX_RCTL: begin
                rd_mux[`FDB_REQ_BIT]              = s_q.tx_rreq;
                rd_mux[`FDB_ACK_BIT]              = s_q.tx_rack;
                rd_mux[`FDB_HI_MSB:`FDB_HI_LSB]   = s_q.tx_rhi;
                rd_mux[TA+1:0]                    = s_q.tx_radx;
            end
            `FDB_OFF_TX_RLO: begin
                rd_mux = s_q.tx_rlo;
            end
            `FDB_OFF_RX_WCTL: begin
                rd_mux[`FDB_REQ_BIT]              = s_q.rx_wreq;
                rd_mux[`FDB_ACK_BIT]              = s_q.rx_wack;
                rd_mux[`FDB_HI_MSB:`FDB_HI_LSB]   = s_q.rx_whi;
                rd_mux[RA+1]                      = s_q.rx_wadx[RA+1];
                rd_mux[RA:0]                      = s_q.rx_wptr;
            end
            `FDB_OFF_RX_WLO: begin
                rd_mux = s_q.rx_wlo;
            end
            `FDB_OFF_RX_RCTL: begin
                rd_mux[`FDB_REQ_BIT]              = s_q.rx_rreq;
                rd_mux[`FDB_ACK_BIT]              = s_q.rx_rack;
                rd_mux[`FDB_HI_MSB:`FDB_HI_LSB]   = s_q.rx_rhi;
                rd_mux[RA+1:0]                    = s_q.rx_radx;
            end
            `FDB_OFF_RX_RLO: begin
                rd_mux = s_q.rx_rlo;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        tx_mem_we = 1'b0;
        rx_mem_we = 1'b0;

        // APB answer: one wait state, error on unmapped address
        // Read data is zero outside the answer cycle of a read
        s_d.pready  = acc_first;
        s_d.pslverr = acc_first && !addr_hit;
        s_d.prdata  = (acc_first && !pwrite) ? rd_mux : `FDB_RST_WORD;

        // Register writes; ack and read-data fields keep their value
        // Writes land at the edge that completes the access phase
        if (acc_done && pwrite) begin
            case (paddr)
                `FDB_OFF_TX_WCTL: begin
                    s_d.tx_wreq = pwdata[`FDB_REQ_BIT];
                    s_d.tx_whi  = pwdata[`FDB_HI_MSB:`FDB_HI_LSB];
                    s_d.tx_wadx = pwdata[TA+1:0];
                end
                `FDB_OFF_TX_WLO: begin
                    s_d.tx_wlo = pwdata;
                end
                `FDB_OFF_TX_RCTL: begin
                    s_d.tx_rreq = pwdata[`FDB_REQ_BIT];
                    s_d.tx_radx = pwdata[TA+1:0];
                end
                `FDB_OFF_RX_WCTL: begin
                    s_d.rx_wreq = pwdata[`FDB_REQ_BIT];
                    s_d.rx_whi  = pwdata[`FDB_HI_MSB:`FDB_HI_LSB];
                    s_d.rx_wadx = pwdata[RA+1:0];
                end
                `FDB_OFF_RX_WLO: begin
                    s_d.rx_wlo = pwdata;
                end
                `FDB_OFF_RX_RCTL: begin
                    s_d.rx_rreq = pwdata[`FDB_REQ_BIT];
                    s_d.rx_radx = pwdata[RA+1:0];
                end
                // Read-low registers and unmapped offsets change nothing
                default: begin
                    s_d.tx_wlo = s_q.tx_wlo;
                end
            endcase
        end

        // Tx write handshake: act on rising request, then ack
        // Request is taken from the register, so the work lands one
        // edge after the bus write that raised it
        if (s_q.tx_wreq && !s_q.tx_wack) begin
            if (s_q.tx_wadx[TA+1]) begin
                s_d.tx_wptr = s_q.tx_wadx[TA:0];
            end else begin
                tx_mem_we = 1'b1;
            end
            s_d.tx_wack = 1'b1;
        end else if (!s_q.tx_wreq && s_q.tx_wack) begin
            s_d.tx_wack = 1'b0;
        end

        // Tx read handshake: capture word or pointer, then ack
        // Read pointer has no load path and keeps its reset value
        if (s_q.tx_rreq && !s_q.tx_rack) begin
            if (s_q.tx_radx[TA+1]) begin
                s_d.tx_rhi = `FDB_RST_BYTE;
                s_d.tx_rlo = `FDB_RST_WORD;
                s_d.tx_rlo[TA:0] = s_q.tx_rptr;
            end else begin
                s_d.tx_rhi = tx_rd_word[CM:CL];
                s_d.tx_rlo = tx_rd_word[LM:0];
            end
            s_d.tx_rack = 1'b1;
        end else if (!s_q.tx_rreq && s_q.tx_rack) begin
            s_d.tx_rack = 1'b0;
        end

        // Rx write handshake: act on rising request, then ack
        // Ack is set by hardware only, so no set and clear can
        // collide in one cycle
        if (s_q.rx_wreq && !s_q.rx_wack) begin
            if (s_q.rx_wadx[RA+1]) begin
                s_d.rx_wptr = s_q.rx_wadx[RA:0];
            end else begin
                rx_mem_we = 1'b1;
            end
            s_d.rx_wack = 1'b1;
        end else if (!s_q.rx_wreq && s_q.rx_wack) begin
            s_d.rx_wack = 1'b0;
        end

        // Rx read handshake: capture word or pointer, then ack
        // Read pointer has no load path and keeps its reset value
        if (s_q.rx_rreq && !s_q.rx_rack) begin
            if (s_q.rx_radx[RA+1]) begin
                s_d.rx_rhi = `FDB_RST_BYTE;
                s_d.rx_rlo = `FDB_RST_WORD;
                s_d.rx_rlo[RA:0] = s_q.rx_rptr;
            end else begin
                s_d.rx_rhi = rx_rd_word[CM:CL];
                s_d.rx_rlo = rx_rd_word[LM:0];
            end
            s_d.rx_rack = 1'b1;
        end else if (!s_q.rx_rreq && s_q.rx_rack) begin
            s_d.rx_rack = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Whole state in one register; reset clears every field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // RAM write ports
    // ----------------------------------------------------------------
    // Tx word keeps control byte with byte-valid code in bits 33:32
    // Write port uses only registered address and data
    always_ff @(posedge pclk) begin
        if (tx_mem_we) begin
            tx_mem[s_q.tx_wadx[TA-1:0]] <= {s_q.tx_whi, s_q.tx_wlo};
        end
    end

    // Rx word: bits 39:36 forced unused, SOF, EOF, byte-valid kept
    always_ff @(posedge pclk) begin
        if (rx_mem_we) begin
            rx_mem[s_q.rx_wadx[RA-1:0]] <= {`FDB_RX_UNUSED, s_q.rx_whi[RK:0], s_q.rx_wlo};
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flops
    // ----------------------------------------------------------------
    // Registered state fields driven straight onto the ports
    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign tx_wr_ptr = s_q.tx_wptr;
    assign tx_rd_ptr = s_q.tx_rptr;
    assign rx_wr_ptr = s_q.rx_wptr;
    assign rx_rd_ptr = s_q.rx_rptr;

endmodule

`default_nettype wire

// ===== tb/fdb_fifo_ram_debug_props.sv
// Port-level assertion checker for the FIFO RAM debug block
`timescale 1ns/100ps
`default_nettype none

module fdb_fifo_ram_debug_props #(
    parameter int unsigned tx_ram_addr_width = 8,
    parameter int unsigned rx_ram_addr_width = 8
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [9:0]                 paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic [tx_ram_addr_width:0] tx_wr_ptr,
    input wire logic [tx_ram_addr_width:0] tx_rd_ptr,
    input wire logic [rx_ram_addr_width:0] rx_wr_ptr,
    input wire logic [rx_ram_addr_width:0] rx_rd_ptr
);
    // ------------------------------------------------------------
    // Helper decode
    // ------------------------------------------------------------
    logic                       mapped;
    logic                       tx_load;
    logic                       rx_load;
    logic [tx_ram_addr_width:0] tx_val;
    logic [rx_ram_addr_width:0] rx_val;

    // Mapped offsets and pointer-load requests
    assign mapped  = paddr[9:5] == 5'h03 && paddr[1:0] == 2'h0;
    assign tx_load = pready && pwrite && paddr == 10'h060 && pwdata[31] && pwdata[tx_ram_addr_width + 1];
    assign rx_load = pready && pwrite && paddr == 10'h070 && pwdata[31] && pwdata[rx_ram_addr_width + 1];
    assign tx_val  = pwdata[tx_ram_addr_width:0];
    assign rx_val  = pwdata[rx_ram_addr_width:0];

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    chk_ready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready missing one cycle into access");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready held for two cycles");
    chk_ready_phase: assert property (pready |-> s_access)
        else $error("pready outside an access phase");
    chk_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("slave error does not match the decode");
    chk_rdata_quiet: assert property (!(pready && !pwrite && mapped) |-> prdata == 32'h0)
        else $error("read data outside a mapped read");
    chk_rd_ptr_rest: assert property (tx_rd_ptr == '0 && rx_rd_ptr == '0)
        else $error("read pointer moved without a load path");
    chk_tx_ptr_only: assert property (
        $changed(tx_wr_ptr) |-> $past(tx_load, 2) && tx_wr_ptr == $past(tx_val, 2))
        else $error("tx write pointer moved without a load");
    chk_tx_ptr_load: assert property (tx_load |-> ##2 tx_wr_ptr == $past(tx_val, 2))
        else $error("tx write pointer not loaded");
    chk_rx_ptr_only: assert property (
        $changed(rx_wr_ptr) |-> $past(rx_load, 2) && rx_wr_ptr == $past(rx_val, 2))
        else $error("rx write pointer moved without a load");
    chk_rx_ptr_load: assert property (rx_load |-> ##2 rx_wr_ptr == $past(rx_val, 2))
        else $error("rx write pointer not loaded");
endmodule

bind fdb_fifo_ram_debug fdb_fifo_ram_debug_props #(
    .tx_ram_addr_width(tx_ram_addr_width),
    .rx_ram_addr_width(rx_ram_addr_width)
) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_wr_ptr(tx_wr_ptr), .tx_rd_ptr(tx_rd_ptr), .rx_wr_ptr(rx_wr_ptr), .rx_rd_ptr(rx_rd_ptr)
);

`default_nettype wire

// ===== tb/tb_fdb_fifo_ram_debug.sv
// Self-checking testbench of the FIFO RAM debug block
`timescale 1ns/100ps
`default_nettype none

module tb_fdb_fifo_ram_debug;
    localparam int TA = 2;
    localparam int RA = 2;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [TA:0] tx_wr_ptr;
    logic [TA:0] tx_rd_ptr;
    logic [RA:0] rx_wr_ptr;
    logic [RA:0] rx_rd_ptr;
    logic [31:0] rd;
    logic        er;
    int          n_fail;
    int          n_tests;

    // Device with four-word RAMs
    fdb_fifo_ram_debug #(.tx_ram_addr_width(TA), .rx_ram_addr_width(RA)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_wr_ptr(tx_wr_ptr), .tx_rd_ptr(tx_rd_ptr), .rx_wr_ptr(rx_wr_ptr), .rx_rd_ptr(rx_rd_ptr)
    );

    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready wait", 32'h1, 32'h0);
    endtask

    // Full request and acknowledge cycle, result taken while ack is high
    task automatic hs(input logic [9:0] a, input logic [31:0] w, output logic [31:0] hi, output logic [31:0] lo);
        int n;
        apb(1'b1, a, w | 32'h8000_0000);
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[30] !== 1'b1 && n < 20);
        hi = rd;
        chk("ack rise", 32'h1, 32'(rd[30]));
        apb(1'b0, a + 10'h4, 32'h0);
        lo = rd;
        apb(1'b1, a, w);
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[30] !== 1'b0 && n < 20);
        chk("ack fall", 32'h0, 32'(rd[30]));
    endtask

    function automatic logic [7:0] ctl(input int i);
        return {6'(i * 13 + 33), 2'(i)};
    endfunction

    // Four words written, then read back in order
    task automatic ram_round(input logic [9:0] base, input logic [7:0] keep);
        logic [31:0] hi;
        logic [31:0] lo;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, base + 10'h4, 32'hC3A5_0F00 + 32'(i));
            apb(1'b0, base + 10'h4, 32'h0);
            chk("low data rw", 32'hC3A5_0F00 + 32'(i), rd);
            hs(base, {8'h0, ctl(i), 16'(i)}, hi, lo);
        end
        for (int i = 0; i < 4; i++) begin
            hs(base + 10'h8, 32'(i), hi, lo);
            chk("read control byte", 32'(ctl(i) & keep), 32'(hi[23:16]));
            chk("read low data", 32'hC3A5_0F00 + 32'(i), lo);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 10'h060 + 10'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
            chk("reset slverr", 32'h0, 32'(er));
        end
        $display("test reset done");
    endtask

    task automatic t_tx_ram();
        ram_round(10'h060, 8'hFF);
        $display("test tx ram done");
    endtask

    task automatic t_rx_ram();
        ram_round(10'h070, 8'h0F);
        $display("test rx ram done");
    endtask

    task automatic t_ptr();
        logic [31:0] hi;
        logic [31:0] lo;
        hs(10'h060, 32'h0000_000D, hi, lo);
        chk("tx wr ptr", 32'h5, 32'(tx_wr_ptr));
        apb(1'b1, 10'h060, 32'h0000_0002);
        apb(1'b0, 10'h060, 32'h0);
        chk("tx live ptr", 32'h0000_0005, rd);
        hs(10'h070, 32'h0000_000E, hi, lo);
        chk("rx wr ptr", 32'h6, 32'(rx_wr_ptr));
        apb(1'b0, 10'h070, 32'h0);
        chk("rx live ptr", 32'h0000_000E, rd);
        hs(10'h068, 32'h0000_0008, hi, lo);
        chk("tx rd ptr read", 32'h0, lo);
        chk("tx rd ptr ctl", 32'h0, 32'(hi[23:16]));
        chk("tx rd ptr pin", 32'h0, 32'(tx_rd_ptr));
        hs(10'h078, 32'h0000_0008, hi, lo);
        chk("rx rd ptr read", 32'h0, lo);
        chk("rx rd ptr pin", 32'h0, 32'(rx_rd_ptr));
        $display("test pointers done");
    endtask

    task automatic t_ignore();
        apb(1'b1, 10'h06C, 32'hFFFF_FFFF);
        apb(1'b0, 10'h06C, 32'h0);
        chk("tx read low ro", 32'h0, rd);
        apb(1'b1, 10'h07C, 32'hFFFF_FFFF);
        apb(1'b0, 10'h07C, 32'h0);
        chk("rx read low ro", 32'h0, rd);
        apb(1'b1, 10'h068, 32'h40FF_0000);
        apb(1'b0, 10'h068, 32'h0);
        chk("tx read ctl ro", 32'h0, rd);
        apb(1'b1, 10'h070, 32'h4000_0000);
        apb(1'b0, 10'h070, 32'h0);
        chk("rx write ack ro", 32'h0000_0006, rd);
        apb(1'b1, 10'h080, 32'hFFFF_FFFF);
        chk("unmapped slverr", 32'h1, 32'(er));
        apb(1'b0, 10'h062, 32'h0);
        chk("unaligned slverr", 32'h1, 32'(er));
        chk("unaligned data", 32'h0, rd);
        $display("test ignored writes done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence; no FIFO data ports, so their I/O stays quiet
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 10'h000;
        pwdata  = 32'h0;
        n_fail  = 0;
        n_tests = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx_ram();
        t_rx_ram();
        t_ptr();
        t_ignore();
        complete_run();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run();
    end
endmodule

`default_nettype wire
